/* File: include/lsas_pkg.sv */
`default_nettype none
package lsas_pkg;
    localparam int RESULT_W = 10;
    localparam int CHAN_N = 8;
    localparam int CHAN_W = 3;
    localparam int CLK_MHZ = 25;
    localparam int CONV_TIME_US = 10;
    localparam int CONV_CYCLES = (CONV_TIME_US * CLK_MHZ);
    localparam int SETTLE_TIME_US = 20;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_US * CLK_MHZ);
    localparam int DAY_SECONDS = 86400;
    localparam longint DAY_CYCLES = longint'(DAY_SECONDS) * longint'(CLK_MHZ) * 64'hF4240;
    localparam int CNT_W = 12;
    localparam int DAY_W = 42;
    localparam logic BANK_V = 1'b0;
    localparam logic BANK_H = 1'b1;
    localparam logic [CHAN_W-1:0] CH_LAST = 3'h7;
    localparam logic [CHAN_W-1:0] CH_SUPPLY_A = 3'h6;
    localparam logic [CHAN_W-1:0] CH_SUPPLY_B = 3'h7;
endpackage
`default_nettype wire

/* File: include/lsas_conv_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface lsas_conv_if;
    logic                       start;
    logic [lsas_pkg::CHAN_W-1:0] chan;
    logic                       done;
    logic [lsas_pkg::RESULT_W-1:0] result;
    modport master (output start, output chan, input done, input result);
    modport timer  (input start, input chan, output done, output result);
endinterface
`default_nettype wire

/* File: hw/lsas_conv_slot.sv */
`timescale 1ns/10ps
`default_nettype none
// Gives each conversion its full time slot, then samples the converter result
module lsas_conv_slot #(
    parameter int SLOT = lsas_pkg::CONV_CYCLES
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire logic [lsas_pkg::RESULT_W-1:0] adcSync,
    lsas_conv_if.timer                         conv
);
    typedef struct packed {
        logic                          busy;
        logic [lsas_pkg::CNT_W-1:0]    count;
        logic                          done;
        logic [lsas_pkg::RESULT_W-1:0] result;
    } lsas_slot_t;

    lsas_slot_t st;
    lsas_slot_t next_st;

    // Slot timer; the result is only taken after the whole bound elapsed
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (!st.busy && conv.start) begin
            next_st.busy = 1'b1;
            next_st.count = lsas_pkg::CNT_W'(SLOT - 1);
        end else if (st.busy) begin
            if (st.count == '0) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.result = adcSync;
            end else begin
                next_st.count = st.count - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign conv.done = st.done;
    assign conv.result = st.result;

    property p_slot_len;
        @(posedge ref_clk) disable iff (!rstn)
        (!st.busy && conv.start) |=> st.busy ##SLOT st.done;
    endproperty
    a_slot_len: assert property (p_slot_len) else $error("slot length wrong");

    // The channel must not move while its conversion is still running
    property p_chan_held;
        @(posedge ref_clk) disable iff (!rstn)
        st.busy |-> $stable(conv.chan);
    endproperty
    a_chan_held: assert property (p_chan_held) else $error("channel moved in slot");
endmodule
`default_nettype wire

/* File: hw/lsas_scan_seq.sv */
`timescale 1ns/10ps
`default_nettype none
module lsas_scan_seq #(
    parameter longint DAY_CYCLES    = lsas_pkg::DAY_CYCLES,
    parameter int     SETTLE_CYCLES = lsas_pkg::SETTLE_CYCLES,
    parameter int     CONV_CYCLES   = lsas_pkg::CONV_CYCLES
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire logic                          scanReq,
    input  wire logic [lsas_pkg::RESULT_W-1:0] adcResult,
    output logic                               bankSelect,
    output logic [lsas_pkg::CHAN_W-1:0]        adcChannel,
    output logic                               scanBusy,
    output logic                               scanReady,
    output logic                               dailyDone,
    output logic [6*lsas_pkg::RESULT_W-1:0]    laserV,
    output logic [6*lsas_pkg::RESULT_W-1:0]    laserH,
    output logic [lsas_pkg::RESULT_W-1:0]      supplyNeg15,
    output logic [lsas_pkg::RESULT_W-1:0]      supply12,
    output logic [lsas_pkg::RESULT_W-1:0]      supplySwitch5,
    output logic [lsas_pkg::RESULT_W-1:0]      supplyCpu5
);
    localparam int RW = lsas_pkg::RESULT_W;

    typedef enum {
        LSAS_IDLE,
        LSAS_SETTLE,
        LSAS_START,
        LSAS_WAIT
    } lsas_state_t;

    typedef struct packed {
        lsas_state_t                       fsm;
        logic [lsas_pkg::RESULT_W-1:0]     adcMeta;
        logic [lsas_pkg::RESULT_W-1:0]     adcSync;
        logic                              bank;
        logic [lsas_pkg::CHAN_W-1:0]       chan;
        logic [lsas_pkg::CNT_W-1:0]        settle;
        logic [lsas_pkg::DAY_W-1:0]        day;
        logic                              daily;
        logic                              pendRemote;
        logic                              pendDaily;
        logic                              busy;
        logic                              ready;
        logic                              dailyDone;
        logic                              convStart;
        logic [6*lsas_pkg::RESULT_W-1:0]   laserV;
        logic [6*lsas_pkg::RESULT_W-1:0]   laserH;
        logic [lsas_pkg::RESULT_W-1:0]     neg15;
        logic [lsas_pkg::RESULT_W-1:0]     pos12;
        logic [lsas_pkg::RESULT_W-1:0]     sw5;
        logic [lsas_pkg::RESULT_W-1:0]     cpu5;
    } lsas_seq_t;

    lsas_seq_t st;
    lsas_seq_t next_st;

    lsas_conv_if conv ();

    // Converter slot timing lives in its own small module
    lsas_conv_slot #(
        .SLOT (CONV_CYCLES)
    ) u_slot (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .adcSync (st.adcSync),
        .conv    (conv.timer)
    );

    assign conv.start = st.convStart;
    assign conv.chan  = st.chan;

    // Sequencer: remote and daily requests are latched so neither is lost mid-scan
    always_comb begin
        next_st = st;
        next_st.adcMeta = adcResult;
        next_st.adcSync = st.adcMeta;
        next_st.convStart = 1'b0;
        next_st.dailyDone = 1'b0;
        if (st.day == '0) begin
            next_st.day = lsas_pkg::DAY_W'(DAY_CYCLES - 1);
            next_st.pendDaily = 1'b1;
        end else begin
            next_st.day = st.day - 1'b1;
        end
        if (scanReq) begin
            next_st.pendRemote = 1'b1;
        end
        case (st.fsm)
            LSAS_IDLE: begin
                if (st.pendRemote || st.pendDaily) begin
                    next_st.daily = !st.pendRemote;
                    next_st.pendRemote = scanReq;
                    next_st.pendDaily = (st.day == '0) ? 1'b1 : 1'b0;
                    next_st.busy = 1'b1;
                    next_st.ready = 1'b0;
                    next_st.bank = lsas_pkg::BANK_V;
                    next_st.chan = '0;
                    next_st.settle = lsas_pkg::CNT_W'(SETTLE_CYCLES - 1);
                    next_st.fsm = LSAS_SETTLE;
                end
            end
            LSAS_SETTLE: begin
                if (st.settle == '0) begin
                    next_st.fsm = LSAS_START;
                end else begin
                    next_st.settle = st.settle - 1'b1;
                end
            end
            LSAS_START: begin
                next_st.convStart = 1'b1;
                next_st.fsm = LSAS_WAIT;
            end
            LSAS_WAIT: begin
                if (conv.done) begin
                    // Route the result by bank and channel
                    if (st.bank == lsas_pkg::BANK_V) begin
                        if (st.chan == lsas_pkg::CH_SUPPLY_A) begin
                            next_st.neg15 = conv.result;
                        end else if (st.chan == lsas_pkg::CH_SUPPLY_B) begin
                            next_st.pos12 = conv.result;
                        end else begin
                            next_st.laserV[st.chan*RW +: RW] = conv.result;
                        end
                    end else begin
                        if (st.chan == lsas_pkg::CH_SUPPLY_A) begin
                            next_st.sw5 = conv.result;
                        end else if (st.chan == lsas_pkg::CH_SUPPLY_B) begin
                            next_st.cpu5 = conv.result;
                        end else begin
                            next_st.laserH[st.chan*RW +: RW] = conv.result;
                        end
                    end
                    if (st.chan != lsas_pkg::CH_LAST) begin
                        next_st.chan = st.chan + 1'b1;
                        next_st.fsm = LSAS_START;
                    end else if (st.bank == lsas_pkg::BANK_V) begin
                        next_st.bank = lsas_pkg::BANK_H;
                        next_st.chan = '0;
                        next_st.settle = lsas_pkg::CNT_W'(SETTLE_CYCLES - 1);
                        next_st.fsm = LSAS_SETTLE;
                    end else begin
                        next_st.busy = 1'b0;
                        next_st.ready = 1'b1;
                        next_st.dailyDone = st.daily;
                        next_st.fsm = LSAS_IDLE;
                    end
                end
            end
            default: begin
                next_st.fsm = LSAS_IDLE;
            end
        endcase
    end

    // Single register for all state; the day counter restarts at reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.fsm <= LSAS_IDLE;
            st.day <= lsas_pkg::DAY_W'(DAY_CYCLES - 1);
        end else begin
            st <= next_st;
        end
    end

    assign bankSelect    = st.bank;
    assign adcChannel    = st.chan;
    assign scanBusy      = st.busy;
    assign scanReady     = st.ready;
    assign dailyDone     = st.dailyDone;
    assign laserV        = st.laserV;
    assign laserH        = st.laserH;
    assign supplyNeg15   = st.neg15;
    assign supply12      = st.pos12;
    assign supplySwitch5 = st.sw5;
    assign supplyCpu5    = st.cpu5;

    sequence s_conv_taken;
        conv.done ##1 (st.fsm == LSAS_START);
    endsequence

    property p_req_starts;
        @(posedge ref_clk) disable iff (!rstn)
        (st.fsm == LSAS_IDLE && scanReq) |-> ##[1:2] (st.busy && st.fsm == LSAS_SETTLE);
    endproperty
    a_req_starts: assert property (p_req_starts) else $error("request not started");

    property p_bank_settle;
        @(posedge ref_clk) disable iff (!rstn)
        $changed(st.bank) |-> (st.fsm == LSAS_SETTLE);
    endproperty
    a_bank_settle: assert property (p_bank_settle) else $error("bank change w/o settle");

    property p_v_first;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(st.busy) |-> (st.bank == lsas_pkg::BANK_V && st.chan == '0);
    endproperty
    a_v_first: assert property (p_v_first) else $error("scan not starting on V ch0");

    property p_chan_step;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.chan != lsas_pkg::CH_LAST) |=> (st.chan == $past(st.chan) + 3'h1);
    endproperty
    a_chan_step: assert property (p_chan_step) else $error("channel did not step");

    property p_v_store;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.bank == lsas_pkg::BANK_V && st.chan == lsas_pkg::CH_SUPPLY_B)
            |=> (st.pos12 == $past(conv.result));
    endproperty
    a_v_store: assert property (p_v_store) else $error("12V not stored");

    property p_h_store;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.bank == lsas_pkg::BANK_H && st.chan == lsas_pkg::CH_SUPPLY_A)
            |=> (st.sw5 == $past(conv.result));
    endproperty
    a_h_store: assert property (p_h_store) else $error("5V switch not stored");

    property p_neg_store;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.bank == lsas_pkg::BANK_V && st.chan == lsas_pkg::CH_SUPPLY_A)
            |=> (st.neg15 == $past(conv.result));
    endproperty
    a_neg_store: assert property (p_neg_store) else $error("-15V not stored");

    property p_cpu_store;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.bank == lsas_pkg::BANK_H && st.chan == lsas_pkg::CH_SUPPLY_B)
            |=> (st.cpu5 == $past(conv.result) && st.ready);
    endproperty
    a_cpu_store: assert property (p_cpu_store) else $error("5V cpu not stored");

    property p_laser_v0;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.bank == lsas_pkg::BANK_V && st.chan == 3'h0)
            |=> (st.laserV[RW-1:0] == $past(conv.result));
    endproperty
    a_laser_v0: assert property (p_laser_v0) else $error("laser V1 not stored");

    property p_laser_h5;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.bank == lsas_pkg::BANK_H && st.chan == 3'h5)
            |=> (st.laserH[6*RW-1 -: RW] == $past(conv.result));
    endproperty
    a_laser_h5: assert property (p_laser_h5) else $error("laser H6 not stored");

    property p_next_conv;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.chan != lsas_pkg::CH_LAST) |-> s_conv_taken;
    endproperty
    a_next_conv: assert property (p_next_conv) else $error("next conversion late");

    property p_daily;
        @(posedge ref_clk) disable iff (!rstn)
        (st.day == '0) |=> st.pendDaily || st.busy;
    endproperty
    a_daily: assert property (p_daily) else $error("daily scan lost");

    // Pass order, daily flag and settling load; a broken swap would mix up the banks
    sequence s_bank_swap;
        ##1 (st.bank == lsas_pkg::BANK_H && st.chan == '0 && st.fsm == LSAS_SETTLE);
    endsequence

    property p_v_then_h;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.bank == lsas_pkg::BANK_V && st.chan == lsas_pkg::CH_LAST)
            |-> s_bank_swap;
    endproperty
    a_v_then_h: assert property (p_v_then_h) else $error("H pass did not follow V");

    property p_daily_flag;
        @(posedge ref_clk) disable iff (!rstn)
        (conv.done && st.bank == lsas_pkg::BANK_H && st.chan == lsas_pkg::CH_LAST && st.daily)
            |=> st.dailyDone;
    endproperty
    a_daily_flag: assert property (p_daily_flag) else $error("daily end not flagged");

    property p_settle_load;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(st.busy) |-> (st.settle == lsas_pkg::CNT_W'(SETTLE_CYCLES - 1));
    endproperty
    a_settle_load: assert property (p_settle_load) else $error("settle not loaded");

    property p_mux_held;
        @(posedge ref_clk) disable iff (!rstn)
        (st.fsm == LSAS_WAIT) |-> ($stable(st.bank) && $stable(st.chan));
    endproperty
    a_mux_held: assert property (p_mux_held) else $error("mux moved in conversion");
endmodule
`default_nettype wire

/* File: verification/lsas_adc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Analog mux stage in front of an eight-input converter with an asynchronous output
module lsas_adc_model (
    input  wire logic                          bankSelect,
    input  wire logic [lsas_pkg::CHAN_W-1:0]   adcChannel,
    input  wire logic [lsas_pkg::RESULT_W-1:0] mask,
    input  wire logic                          slow,
    output logic      [lsas_pkg::RESULT_W-1:0] adcResult
);
    logic [lsas_pkg::RESULT_W-1:0] level;

    // Sixteen distinct levels, two per converter input, picked by the bank select
    assign level = (10'({bankSelect, adcChannel}) * 10'h25 + 10'h11) ^ mask;

    // A slow input shows the inverted code while settling, so a stale sample is never right
    always @(level or slow) begin
        adcResult = slow ? ~level : level;
        adcResult <= #60 level;
    end
endmodule
`default_nettype wire

/* File: verification/lsas_scan_seq_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) checkEq(64'(got), 64'(exp))
module lsas_scan_seq_bench;
    localparam int SETTLE = 4;
    localparam int CONV   = 4;
    localparam int DAY    = 5000;
    localparam int LIMIT  = 2 * DAY + 3000;

    logic        ref_clk;
    logic        rstn;
    logic        scanReq;
    logic [9:0]  adcResult;
    logic [9:0]  mask;
    logic        slow;
    logic        bankSelect;
    logic [2:0]  adcChannel;
    logic        scanBusy;
    logic        scanReady;
    logic        dailyDone;
    logic [59:0] laserV;
    logic [59:0] laserH;
    logic [9:0]  supplyNeg15;
    logic [9:0]  supply12;
    logic [9:0]  supplySwitch5;
    logic [9:0]  supplyCpu5;
    int          n_mismatch;
    int          checks;
    int          cyc;
    int          stamp [16];
    int          bankRise;
    int          busyRise;
    logic [3:0]  prevPos;
    logic        prevBusy;

    lsas_scan_seq #(
        .DAY_CYCLES   (longint'(DAY)),
        .SETTLE_CYCLES(SETTLE),
        .CONV_CYCLES  (CONV)
    ) i_lsas_scan_seq (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .scanReq      (scanReq),
        .adcResult    (adcResult),
        .bankSelect   (bankSelect),
        .adcChannel   (adcChannel),
        .scanBusy     (scanBusy),
        .scanReady    (scanReady),
        .dailyDone    (dailyDone),
        .laserV       (laserV),
        .laserH       (laserH),
        .supplyNeg15  (supplyNeg15),
        .supply12     (supply12),
        .supplySwitch5(supplySwitch5),
        .supplyCpu5   (supplyCpu5)
    );

    lsas_adc_model i_lsas_adc_model (
        .bankSelect(bankSelect),
        .adcChannel(adcChannel),
        .mask      (mask),
        .slow      (slow),
        .adcResult (adcResult)
    );

    // Free-running clock, 40 ns period
    always #20 ref_clk = ~ref_clk;

    // Stamps the cycle of each channel step; also cuts a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        prevPos <= {bankSelect, adcChannel};
        prevBusy <= scanBusy;
        if (scanBusy && {bankSelect, adcChannel} != prevPos) begin
            stamp[{bankSelect, adcChannel}] <= cyc;
        end
        if (bankSelect && !prevPos[3]) begin
            bankRise <= cyc;
        end
        if (scanBusy && !prevBusy) begin
            busyRise <= cyc;
        end
        if (cyc == LIMIT) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // Own reference for the level each bank and channel carries
    function automatic logic [9:0] expVal(input logic b, input logic [2:0] c, input logic [9:0] s);
        return (10'({b, c}) * 10'h25 + 10'h11) ^ s;
    endfunction

    task automatic checkEq(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic checkStore(input logic [9:0] s);
        for (int i = 0; i < 6; i++) begin
            `CHK(laserV[i*10 +: 10], expVal(lsas_pkg::BANK_V, 3'(i), s));
            `CHK(laserH[i*10 +: 10], expVal(lsas_pkg::BANK_H, 3'(i), s));
        end
        `CHK(supplyNeg15, expVal(lsas_pkg::BANK_V, 3'h6, s));
        `CHK(supply12, expVal(lsas_pkg::BANK_V, 3'h7, s));
        `CHK(supplySwitch5, expVal(lsas_pkg::BANK_H, 3'h6, s));
        `CHK(supplyCpu5, expVal(lsas_pkg::BANK_H, 3'h7, s));
    endtask

    // Step order and spacing of the last scan, V pass before H pass
    task automatic checkTiming();
        for (int k = 2; k < 16; k++)
            `CHK(stamp[k] - stamp[k-1] >= CONV, 1'b1);
        `CHK(stamp[1] - busyRise >= SETTLE + CONV, 1'b1);
        `CHK(stamp[9] - bankRise >= SETTLE + CONV, 1'b1);
    endtask

    task automatic waitBusy(input logic level);
        for (int n = 0; n < 400 && scanBusy !== level; n++)
            @(negedge ref_clk);
    endtask

    task automatic pulseReq();
        scanReq = 1'b1;
        @(negedge ref_clk);
        scanReq = 1'b0;
    endtask

    task automatic finishScan(input logic [9:0] s);
        for (int n = 0; n < 400 && scanReady !== 1'b1; n++)
            @(negedge ref_clk);
        `CHK(scanReady, 1'b1);
        `CHK(scanBusy, 1'b0);
        checkStore(s);
        checkTiming();
    endtask

    // A remote request starts one full two-pass scan
    task automatic scanRemote(input logic [9:0] s, input logic slowMode);
        mask = s;
        slow = slowMode;
        pulseReq();
        for (int n = 0; n < 3 && scanBusy !== 1'b1; n++)
            @(negedge ref_clk);
        `CHK(scanBusy, 1'b1);
        `CHK(scanReady, 1'b0);
        finishScan(s);
    endtask

    // A request during a scan is held and runs straight after it
    task automatic scanQueued(input logic [9:0] s);
        mask = s;
        pulseReq();
        waitBusy(1'b1);
        repeat (20) @(negedge ref_clk);
        pulseReq();
        waitBusy(1'b0);
        for (int n = 0; n < 3 && scanBusy !== 1'b1; n++)
            @(negedge ref_clk);
        `CHK(scanBusy, 1'b1);
        finishScan(s);
    endtask

    // Without any request the periodic scan still refreshes the stored levels
    task automatic scanDaily(input logic [9:0] s);
        mask = s;
        for (int n = 0; n < 2 * DAY + 400 && dailyDone !== 1'b1; n++)
            @(negedge ref_clk);
        `CHK(dailyDone, 1'b1);
        @(negedge ref_clk);
        `CHK(dailyDone, 1'b0);
        checkStore(s);
    endtask

    // A reset in mid-scan must clear every output again
    task automatic resetMidScan(input logic [9:0] s);
        mask = s;
        pulseReq();
        waitBusy(1'b1);
        repeat (30) @(negedge ref_clk);
        `CHK(scanBusy, 1'b1);
        applyReset();
    endtask

    task automatic applyReset();
        rstn = 1'b0;
        repeat (6) @(negedge ref_clk);
        `CHK({scanBusy, scanReady, dailyDone, bankSelect, adcChannel}, 7'h00);
        `CHK(|{laserV, laserH, supplyNeg15, supply12, supplySwitch5, supplyCpu5}, 1'b0);
        rstn = 1'b1;
        @(negedge ref_clk);
    endtask

    // Summary and verdict
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        scanReq = 1'b0;
        mask = 10'h000;
        slow = 1'b0;
        n_mismatch = 0;
        checks = 0;
        cyc = 0;
        applyReset();
        scanRemote(10'h000, 1'b0);
        scanRemote(10'h3A5, 1'b1);
        scanQueued(10'h15C);
        resetMidScan(10'h2F0);
        scanDaily(10'h0C3);
        wrap_up();
    end
endmodule
`default_nettype wire
